// >>> src/au_cmd_unit.sv
`timescale 1ns/1ps
// Behaviour
// RULE1 - log10 replaces top float, keeps B
// RULE2 - log10 of non-positive gives error 0100
// RULE3 - log10 takes 4474 cycles, 20 on error
// RULE4 - ln replaces top float; non-positive gives 0100
// RULE5 - ln takes 4298 cycles, 20 on error
// RULE6 - idle finishes in 4 cycles, stack untouched
// RULE7 - idle clears the whole status byte
// RULE8 - command bit 7 drives service request line
// RULE9 - both 32-bit pops rotate up, 12 cycles
// RULE10 - 16-bit pop rotates up, 10 cycles
// RULE11 - both 32-bit dups push copy, 20 cycles
// RULE12 - 16-bit dup pushes copy, 16 cycles
// RULE13 - push pi pushes constant, 16 cycles
// RULE14 - power puts B^A on raised stack
// RULE15 - power errors: base 0100, range 1100
// RULE16 - 16-bit add with carry and overflow
// RULE17 - 16-bit divide gives quotient, 84 cycles
// RULE18 - zero divisor returns dividend, 14 cycles
// RULE19 - sine replaces top, 30 cycles if tiny
// RULE20 - low multiply, overflow on nonzero high half
// RULE21 - most negative multiplicand returns itself, overflow
// RULE22 - one circular store for both views
module au_cmd_unit
  import au_pkg::*;
#(
  parameter int LOG10_CYC = 4474, // common log run length
  parameter int LN_CYC    = 4298, // natural log run length
  parameter int PWR_CYC   = 8290  // power run length
) (
  input  wire logic        clk_i,          // device clock
  input  wire logic        srst_i,         // sync reset, active high
  input  wire logic        cmd_valid_i,    // command byte offered
  input  wire logic [7:0]  cmd_i,          // command byte, bit 7 service request
  output logic             cmd_ready_o,    // unit idle, command taken
  input  wire logic        dat_wr_i,       // push operand byte
  input  wire logic        dat_rd_i,       // pop operand byte
  input  wire logic [7:0]  dat_i,          // byte to push
  output logic [7:0]       dat_o,          // last popped byte
  output logic             busy_o,         // command executing
  output logic             done_o,         // last cycle of a command
  output au_stat_s         status_o,       // status byte
  output logic             svc_req_o,      // service request line
  input  wire logic        svc_ack_i,      // release service request
  output logic             fn_start_o,     // start function evaluator
  output au_fn_e           fn_sel_o,       // function to evaluate
  output logic [31:0]      fn_a_o,         // operand at top
  output logic [31:0]      fn_b_o,         // operand at next
  input  wire logic [31:0] fn_result_i,    // function result
  input  wire logic        fn_range_err_i  // power exponent out of range
);

  au_state_s        r;
  au_state_s        nxt;
  au_stk_op_s       stk_op;
  logic [31:0]      tos32;
  logic [31:0]      nos32;
  logic [15:0]      tos16;
  logic [15:0]      nos16;
  logic             go;
  logic             a_nonpos;
  logic             b_nonpos;
  logic             a_small;
  logic [16:0]      sum17;
  logic [31:0]      prod32;
  logic [15:0]      quot16;
  au_cmd_e          cmd_in;

  au_stack u_stack (
    .clk_i   (clk_i),
    .srst_i  (srst_i),
    .op_i    (stk_op),
    .tos32_o (tos32),
    .nos32_o (nos32)
  );

  ////////////////////////////////////////////////////////////////////////////
  // operand views and arithmetic
  assign tos16    = tos32[31:16];
  assign nos16    = tos32[15:0];
  assign cmd_in   = au_cmd_e'(cmd_i[6:0]);
  assign go       = (r.fsm == ST_IDLE) && cmd_valid_i;
  assign a_nonpos = tos32[FLT_SIGN] || (tos32[30:0] == '0);
  assign b_nonpos = nos32[FLT_SIGN] || (nos32[30:0] == '0);
  assign a_small  = tos32[30:0] <= SIN_SMALL_MAG;
  assign sum17    = {1'b0, nos16} + {1'b0, tos16};
  assign prod32   = 32'($signed(nos16) * $signed(tos16));
  // divider only looked at when the divisor is non-zero
  assign quot16   = (tos16 == '0) ? nos16 : 16'($signed(nos16) / $signed(tos16));

  assign cmd_ready_o = (r.fsm == ST_IDLE);
  assign busy_o      = (r.fsm == ST_RUN);
  assign done_o      = (r.fsm == ST_RUN) && (r.cnt == '0);
  assign dat_o       = r.dout;
  assign status_o    = r.stat;
  assign svc_req_o   = r.svc;
  assign fn_start_o  = r.fn_start;
  assign fn_sel_o    = r.fn_sel;
  // stack is frozen while running, so these stay steady for the evaluator
  assign fn_a_o      = tos32;
  assign fn_b_o      = nos32;

  function automatic au_stat_s flags32(logic [31:0] v);
    au_stat_s s;
    s      = '0;
    s.sign = v[FLT_SIGN];
    s.zero = (v == '0);
    return s;
  endfunction

  function automatic au_stat_s flags16(logic [15:0] v);
    au_stat_s s;
    s      = '0;
    s.sign = v[15];
    s.zero = (v == '0);
    return s;
  endfunction

  function automatic logic [CNT_W-1:0] run_len(au_cmd_e c, logic np, logic sm, logic dz);
    logic [CNT_W-1:0] n;
    n = CYC_IDLE;
    case (c)
      common_log_cmd:         n = np ? CYC_FN_ERR : CNT_W'(LOG10_CYC); // RULE3
      base_e_inverse_exp_cmd: n = np ? CYC_FN_ERR : CNT_W'(LN_CYC);    // RULE5
      idle_cmd:               n = CYC_IDLE;                            // RULE6
      rotate_up_double_cmd,
      rotate_up_float_cmd:    n = CYC_POP32;                           // RULE9
      rotate_up_short_cmd:    n = CYC_POP16;                           // RULE10
      dup_top_double_cmd,
      dup_top_float_cmd:      n = CYC_DUP32;                           // RULE11
      dup_top_short_cmd:      n = CYC_DUP16;                           // RULE12
      push_pi_cmd:            n = CYC_PI;                              // RULE13
      raise_power_cmd:        n = CNT_W'(PWR_CYC);                     // RULE14
      short_add_cmd:          n = CYC_SADD;                            // RULE16
      short_divide_cmd:       n = dz ? CYC_SDIV0 : CYC_SHORT_DIVIDE_CMD;           // RULE17 RULE18
      circular_ordinate_cmd:  n = sm ? CYC_SIN_SMALL : CYC_SIN;        // RULE19
      short_multiply_low_cmd: n = CYC_SHORT_MULTIPLY_LOW_CMD;                            // RULE20
      default:                n = CYC_IDLE;
    endcase
    return n;
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // command sequencer
  always_comb begin
    nxt          = r;
    stk_op       = '0;
    nxt.fn_start = 1'b0;
    if (svc_ack_i) begin
      nxt.svc = 1'b0;
    end
    case (r.fsm)
      ST_IDLE: begin
        if (cmd_valid_i) begin
          nxt.fsm = ST_RUN;
          nxt.op  = cmd_in;
          nxt.sr  = cmd_i[SR_BIT]; // RULE8
          nxt.cnt = run_len(cmd_in, a_nonpos, a_small, tos16 == '0) - CNT_W'(1);
          case (cmd_in)
            common_log_cmd: begin
              nxt.fn_sel   = fn_common_log;
              nxt.fn_start = ~a_nonpos;
            end
            base_e_inverse_exp_cmd: begin
              nxt.fn_sel   = fn_natural_log;
              nxt.fn_start = ~a_nonpos;
            end
            circular_ordinate_cmd: begin
              nxt.fn_sel   = fn_sine;
              nxt.fn_start = 1'b1;
            end
            raise_power_cmd: begin
              nxt.fn_sel   = fn_power;
              nxt.fn_start = ~b_nonpos;
            end
            default: nxt.fn_sel = r.fn_sel;
          endcase
        end else if (dat_wr_i) begin
          stk_op.delta = MV_DN8;
          stk_op.len   = LEN_8;
          stk_op.wdata = {dat_i, 24'h000000};
        end else if (dat_rd_i) begin
          stk_op.delta = MV_UP8;
          nxt.dout     = tos32[31:24];
        end
      end
      ST_RUN: begin
        if (r.cnt != '0) begin
          nxt.cnt = r.cnt - CNT_W'(1);
        end else begin
          nxt.fsm = ST_IDLE;
          nxt.svc = r.sr; // RULE8
          case (r.op)
            idle_cmd: nxt.stat = '0; // RULE6 RULE7
            common_log_cmd,
            base_e_inverse_exp_cmd: begin
              if (a_nonpos) begin
                nxt.stat     = flags32(tos32);
                nxt.stat.err = ERR_DOMAIN; // RULE2 RULE4
              end else begin
                stk_op.len   = LEN_32; // RULE1 RULE4
                stk_op.wdata = fn_result_i;
                nxt.stat     = flags32(fn_result_i);
              end
            end
            circular_ordinate_cmd: begin
              stk_op.len   = LEN_32; // RULE19
              stk_op.wdata = fn_result_i;
              nxt.stat     = flags32(fn_result_i);
            end
            raise_power_cmd: begin
              stk_op.delta = MV_UP32; // RULE14
              stk_op.len   = LEN_32;
              if (b_nonpos) begin
                stk_op.wdata = nos32;
                nxt.stat     = flags32(nos32);
                nxt.stat.err = ERR_DOMAIN; // RULE15
              end else begin
                stk_op.wdata = fn_result_i;
                nxt.stat     = flags32(fn_result_i);
                nxt.stat.err = fn_range_err_i ? ERR_RANGE : ERR_NONE; // RULE15
              end
            end
            rotate_up_double_cmd,
            rotate_up_float_cmd: begin
              stk_op.delta = MV_UP32; // RULE9
              nxt.stat     = flags32(nos32);
            end
            rotate_up_short_cmd: begin
              stk_op.delta = MV_UP16; // RULE10
              nxt.stat     = flags16(nos16);
            end
            dup_top_double_cmd,
            dup_top_float_cmd: begin
              stk_op.delta = MV_DN32; // RULE11
              stk_op.len   = LEN_32;
              stk_op.wdata = tos32;
              nxt.stat     = flags32(tos32);
            end
            dup_top_short_cmd: begin
              stk_op.delta = MV_DN16; // RULE12
              stk_op.len   = LEN_16;
              stk_op.wdata = {tos16, 16'h0000};
              nxt.stat     = flags16(tos16);
            end
            push_pi_cmd: begin
              stk_op.delta = MV_DN32; // RULE13
              stk_op.len   = LEN_32;
              stk_op.wdata = FLT_PI;
              nxt.stat     = flags32(FLT_PI);
            end
            short_add_cmd: begin
              stk_op.delta   = MV_UP16; // RULE16
              stk_op.len     = LEN_16;
              stk_op.wdata   = {sum17[15:0], 16'h0000};
              nxt.stat       = flags16(sum17[15:0]);
              nxt.stat.carry = sum17[16];
              nxt.stat.ovf   = (nos16[15] == tos16[15]) && (sum17[15] != tos16[15]);
            end
            short_divide_cmd: begin
              stk_op.delta = MV_UP16; // RULE17
              stk_op.len   = LEN_16;
              stk_op.wdata = {quot16, 16'h0000};
              nxt.stat     = flags16(quot16);
              if (tos16 == '0) begin
                nxt.stat.err = ERR_DIV0; // RULE18
              end
            end
            short_multiply_low_cmd: begin
              stk_op.delta = MV_UP16;
              stk_op.len   = LEN_16;
              if ((tos16 == S16_MNEG) || (nos16 == S16_MNEG)) begin
                stk_op.wdata = {S16_MNEG, 16'h0000}; // RULE21
                nxt.stat     = flags16(S16_MNEG);
                nxt.stat.ovf = 1'b1;
              end else begin
                stk_op.wdata = {prod32[15:0], 16'h0000}; // RULE20
                nxt.stat     = flags16(prod32[15:0]);
                nxt.stat.ovf = (prod32[31:16] != '0);
              end
            end
            default: nxt.stat = r.stat;
          endcase
        end
      end
      default: nxt.fsm = ST_IDLE;
    endcase
  end

  always_ff @(posedge clk_i) begin
    if (srst_i) begin
      r <= '0;
    end else begin
      r <= nxt;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (srst_i);

  a_idle_len: assert property (go && cmd_i[6:0] == idle_cmd |-> ##4 done_o ##1 // RULE6
    (tos32 == $past(tos32, 5)) && (nos32 == $past(nos32, 5)))
    else $error("idle command length or stack wrong");
  a_idle_status: assert property (done_o && r.op == idle_cmd |=> status_o == '0) // RULE7
    else $error("idle command left status set");
  a_svc_line: assert property (done_o |=> svc_req_o == $past(r.sr)) // RULE8
    else $error("service request does not follow command bit");
  a_pop_double: assert property (go && (cmd_in == rotate_up_double_cmd || // RULE9
    cmd_in == rotate_up_float_cmd) |-> ##12 done_o ##1 tos32 == $past(nos32, 13))
    else $error("32-bit rotate wrong");
  a_pop_short: assert property (go && cmd_in == rotate_up_short_cmd |-> // RULE10
    ##10 done_o ##1 tos16 == $past(nos16, 11))
    else $error("16-bit rotate wrong");
  a_dup_double: assert property (go && (cmd_in == dup_top_double_cmd || // RULE11
    cmd_in == dup_top_float_cmd) |-> ##20 done_o ##1
    (tos32 == $past(tos32, 21)) && (nos32 == $past(tos32, 21)))
    else $error("32-bit duplicate wrong");
  a_dup_short: assert property (go && cmd_in == dup_top_short_cmd |-> // RULE12
    ##16 done_o ##1 (tos16 == $past(tos16, 17)) && (nos16 == $past(tos16, 17)))
    else $error("16-bit duplicate wrong");
  a_push_pi: assert property (go && cmd_in == push_pi_cmd |-> ##16 done_o ##1 // RULE13
    (tos32 == FLT_PI) && (nos32 == $past(tos32, 17)))
    else $error("push pi wrong");
  a_log_domain: assert property (go && cmd_in == common_log_cmd && a_nonpos |-> // RULE2
    ##20 done_o ##1 status_o.err == ERR_DOMAIN)
    else $error("log of non-positive value not flagged in 20 cycles");
  a_add_sum: assert property (go && cmd_in == short_add_cmd |-> ##16 done_o ##1 // RULE16
    (tos16 == $past(sum17[15:0], 17)) && (status_o.carry == $past(sum17[16], 17)))
    else $error("16-bit add result or carry wrong");
  a_div_zero: assert property (go && cmd_in == short_divide_cmd && tos16 == '0 |-> // RULE18
    ##14 done_o ##1 (tos16 == $past(nos16, 15)) && (status_o.err == ERR_DIV0))
    else $error("divide by zero handling wrong");
  a_mul_mneg: assert property (go && cmd_in == short_multiply_low_cmd && // RULE21
    (tos16 == S16_MNEG || nos16 == S16_MNEG) |-> ##84 done_o ##1
    (tos16 == S16_MNEG) && status_o.ovf)
    else $error("most negative multiplicand not returned");

  c_idle_done: cover property (done_o && r.op == idle_cmd);
  c_div_zero: cover property (done_o && r.op == short_divide_cmd ##1 status_o.err == ERR_DIV0);
  c_mul_ovf: cover property (done_o && r.op == short_multiply_low_cmd ##1 status_o.ovf);
  c_log_err: cover property (done_o && r.op == common_log_cmd ##1 status_o.err == ERR_DOMAIN);

endmodule // au_cmd_unit

// >>> src/au_pkg.sv
package au_pkg;

  ////////////////////////////////////////////////////////////////////////////
  // stack geometry: one circular byte store, seen as 4x32 or 8x16
  localparam int STK_BYTES = 16;
  localparam int PTR_W     = 4;
  localparam int CNT_W     = 14;
  localparam int SR_BIT    = 7;
  localparam int FLT_SIGN  = 31;

  // pointer moves, two's complement on PTR_W bits
  localparam logic [PTR_W-1:0] MV_NONE = 4'h0;
  localparam logic [PTR_W-1:0] MV_UP8  = 4'h1;
  localparam logic [PTR_W-1:0] MV_DN8  = 4'hf;
  localparam logic [PTR_W-1:0] MV_UP16 = 4'h2;
  localparam logic [PTR_W-1:0] MV_DN16 = 4'he;
  localparam logic [PTR_W-1:0] MV_UP32 = 4'h4;
  localparam logic [PTR_W-1:0] MV_DN32 = 4'hc;

  // bytes written at the new top, taken from the high end of wdata
  localparam logic [2:0] LEN_0 = 3'h0;
  localparam logic [2:0] LEN_8 = 3'h1;
  localparam logic [2:0] LEN_16 = 3'h2;
  localparam logic [2:0] LEN_32 = 3'h4;

  ////////////////////////////////////////////////////////////////////////////
  // execution lengths in clock cycles
  localparam logic [CNT_W-1:0] CYC_FN_ERR    = 14'h0014;
  localparam logic [CNT_W-1:0] CYC_IDLE      = 14'h0004;
  localparam logic [CNT_W-1:0] CYC_POP32     = 14'h000c;
  localparam logic [CNT_W-1:0] CYC_POP16     = 14'h000a;
  localparam logic [CNT_W-1:0] CYC_DUP32     = 14'h0014;
  localparam logic [CNT_W-1:0] CYC_DUP16     = 14'h0010;
  localparam logic [CNT_W-1:0] CYC_PI        = 14'h0010;
  localparam logic [CNT_W-1:0] CYC_SADD      = 14'h0010;
  localparam logic [CNT_W-1:0] CYC_SHORT_DIVIDE_CMD      = 14'h0054;
  localparam logic [CNT_W-1:0] CYC_SDIV0     = 14'h000e;
  localparam logic [CNT_W-1:0] CYC_SHORT_MULTIPLY_LOW_CMD      = 14'h0054;
  localparam logic [CNT_W-1:0] CYC_SIN       = 14'h0ed4;
  localparam logic [CNT_W-1:0] CYC_SIN_SMALL = 14'h001e;

  ////////////////////////////////////////////////////////////////////////////
  // operand constants and error codes
  localparam logic [31:0] FLT_PI        = 32'h4049_0fdb;
  localparam logic [30:0] SIN_SMALL_MAG = 31'h3980_0000;
  localparam logic [15:0] S16_MNEG      = 16'h8000;
  localparam logic [3:0]  ERR_NONE      = 4'h0;
  localparam logic [3:0]  ERR_DOMAIN    = 4'h4;
  localparam logic [3:0]  ERR_RANGE     = 4'hc;
  localparam logic [3:0]  ERR_DIV0      = 4'h8;

  typedef enum logic [6:0] {
    idle_cmd               = 7'h00,
    circular_ordinate_cmd  = 7'h02,
    common_log_cmd         = 7'h08,
    base_e_inverse_exp_cmd = 7'h09,
    raise_power_cmd        = 7'h0b,
    dup_top_float_cmd      = 7'h17,
    rotate_up_float_cmd    = 7'h18,
    push_pi_cmd            = 7'h1a,
    dup_top_double_cmd     = 7'h37,
    rotate_up_double_cmd   = 7'h38,
    short_add_cmd          = 7'h6c,
    short_multiply_low_cmd = 7'h6e,
    short_divide_cmd       = 7'h6f,
    dup_top_short_cmd      = 7'h77,
    rotate_up_short_cmd    = 7'h78
  } au_cmd_e;

  typedef enum logic [1:0] {
    fn_common_log  = 2'h0,
    fn_natural_log = 2'h1,
    fn_sine        = 2'h2,
    fn_power       = 2'h3
  } au_fn_e;

  typedef enum logic [0:0] {
    ST_IDLE = 1'b0,
    ST_RUN  = 1'b1
  } au_fsm_e;

  typedef struct packed {
    logic       sign;
    logic       zero;
    logic [3:0] err;
    logic       carry;
    logic       ovf;
  } au_stat_s;

  typedef struct packed {
    logic [PTR_W-1:0] delta;
    logic [2:0]       len;
    logic [31:0]      wdata;
  } au_stk_op_s;

  typedef struct packed {
    logic [STK_BYTES-1:0][7:0] mem;
    logic [PTR_W-1:0]          ptr;
  } au_stk_s;

  typedef struct packed {
    au_fsm_e          fsm;
    au_cmd_e          op;
    logic             sr;
    logic [CNT_W-1:0] cnt;
    au_stat_s         stat;
    logic             svc;
    logic [7:0]       dout;
    logic             fn_start;
    au_fn_e           fn_sel;
  } au_state_s;

endpackage

// >>> src/au_stack.sv
`timescale 1ns/1ps
module au_stack
  import au_pkg::*;
(
  input  wire logic        clk_i,   // device clock
  input  wire logic        srst_i,  // sync reset, active high
  input  wire au_stk_op_s  op_i,    // move then write at new top
  output logic [31:0]      tos32_o, // 32-bit top entry
  output logic [31:0]      nos32_o  // 32-bit next entry
);

  au_stk_s                   r;
  au_stk_s                   nxt;
  logic [PTR_W-1:0]          new_ptr;
  logic [STK_BYTES-1:0]      wr_en;
  logic [STK_BYTES-1:0][7:0] wr_byte;
  logic [7:0][7:0]           view;

  assign new_ptr = r.ptr + op_i.delta; // RULE22

  ////////////////////////////////////////////////////////////////////////////
  // one byte store serves both views, so rotations keep them consistent
  genvar g;
  generate
    for (g = 0; g < STK_BYTES; g++) begin : g_byte
      logic [PTR_W-1:0] off;
      assign off        = PTR_W'(g) - new_ptr;
      assign wr_en[g]   = off < PTR_W'(op_i.len);
      assign wr_byte[g] = op_i.wdata[8 * (3 - int'(off[1:0])) +: 8];
    end
    for (g = 0; g < 8; g++) begin : g_view
      assign view[g] = r.mem[r.ptr + PTR_W'(g)]; // RULE22
    end
  endgenerate

  assign tos32_o = {view[0], view[1], view[2], view[3]};
  assign nos32_o = {view[4], view[5], view[6], view[7]};

  always_comb begin
    nxt     = r;
    nxt.ptr = new_ptr;
    for (int i = 0; i < STK_BYTES; i++) begin
      if (wr_en[i]) begin
        nxt.mem[i] = wr_byte[i];
      end
    end
  end

  always_ff @(posedge clk_i) begin
    if (srst_i) begin
      r <= '0;
    end else begin
      r <= nxt;
    end
  end

endmodule // au_stack

// >>> verification/au_fn_model.sv
`timescale 1ns/1ps
module au_fn_model
  import au_pkg::*;
(
  input  wire logic        clk_i,         // device clock
  input  wire logic        fn_start_i,    // evaluation start
  input  wire au_fn_e      fn_sel_i,      // function chosen
  input  wire logic [31:0] fn_a_i,        // top operand
  input  wire logic        bad_range_i,   // bench orders a range fault
  output logic [31:0]      fn_result_o,   // evaluation result
  output logic             fn_range_err_o // exponent out of range
);
  // stand-in math: inverted operand, enough to trace the data path
  always @(posedge clk_i) begin
    if (fn_start_i) begin
      fn_result_o    <= ~fn_a_i;
      fn_range_err_o <= bad_range_i && (fn_sel_i == fn_power);
    end
  end
endmodule // au_fn_model

// >>> verification/tb_top.sv
`timescale 1ns/1ps
module tb_top
  import au_pkg::*;
;
  logic        clk_i = 1'b0;
  logic        srst_i = 1'b1;
  logic        cmd_valid = 1'b0, svc_ack = 1'b0, bad_rng = 1'b0, dat_wr = 1'b0, dat_rd = 1'b0;
  logic [7:0]  cmd = 8'h00, dat = 8'h00, dat_q;
  logic        done, svc_req, fn_start, fn_err, busy, rdy;
  au_stat_s    st;
  au_fn_e      fn_sel;
  logic [31:0] top, nxt, fn_res;
  int          bad_count = 0, checks_done = 0, cyc = 0, n;

  always #2.5 clk_i = ~clk_i;

  au_cmd_unit #(.LOG10_CYC(40), .LN_CYC(40), .PWR_CYC(40)) dut (
    .clk_i(clk_i), .srst_i(srst_i), .cmd_valid_i(cmd_valid), .cmd_i(cmd),
    .cmd_ready_o(rdy), .dat_wr_i(dat_wr), .dat_rd_i(dat_rd), .dat_i(dat), .dat_o(dat_q),
    .busy_o(busy), .done_o(done), .status_o(st), .svc_req_o(svc_req), .svc_ack_i(svc_ack),
    .fn_start_o(fn_start), .fn_sel_o(fn_sel), .fn_a_o(top), .fn_b_o(nxt),
    .fn_result_i(fn_res), .fn_range_err_i(fn_err));
  au_fn_model mdl (.clk_i(clk_i), .fn_start_i(fn_start), .fn_sel_i(fn_sel), .fn_a_i(top),
    .bad_range_i(bad_rng), .fn_result_o(fn_res), .fn_range_err_o(fn_err));

  ////////////////////////////////////////////////////////////////////////////
  task automatic end_of_test();
    $display("checks %0d mismatches %0d", checks_done, bad_count);
    if (bad_count == 0 && checks_done > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    checks_done++;
    if (seen !== exp) begin
      bad_count++;
      $display("unexpected at %0t: saw %h want %h", $time, seen, exp);
    end
  endtask
  // lsb first, so the msb lands on top
  task automatic put32(input logic [31:0] v);
    for (int i = 0; i < 4; i++) begin
      @(negedge clk_i);
      dat_wr = 1'b1;
      dat = v[8*i +: 8];
    end
    @(negedge clk_i);
    dat_wr = 1'b0;
  endtask
  // returns in the first cycle after done, where results have landed
  task automatic run(input logic [7:0] c, input int exp_n);
    @(negedge clk_i);
    cmd_valid = 1'b1;
    cmd = c;
    @(negedge clk_i);
    cmd_valid = 1'b0;
    n = 1;
    while (done !== 1'b1 && n < 5000) begin
      @(negedge clk_i);
      n++;
    end
    chk(32'(n), 32'(exp_n));
    chk({30'h0, busy, rdy}, 32'h2);
    @(negedge clk_i);
    chk({30'h0, busy, rdy}, 32'h1);
  endtask
  // pops come out msb first, one byte per edge
  task automatic t_pop();
    put32(32'h1234_5678);
    dat_rd = 1'b1;
    for (int i = 3; i >= 0; i--) begin
      @(negedge clk_i);
      chk({24'h0, dat_q}, {24'h0, 8'(32'h1234_5678 >> (8 * i))});
    end
    dat_rd = 1'b0;
  endtask

  ////////////////////////////////////////////////////////////////////////////
  task automatic t_stack();
    put32(32'h1111_2222);
    put32(32'h3333_4444);
    run(8'hb8, 12);
    chk(top, 32'h1111_2222);
    run(8'h38, 12);
    run(8'h98, 12);
    run(8'h18, 12);
    chk(nxt, 32'h1111_2222);
    run(8'hf8, 10);
    chk(top, 32'h4444_1111);
    run(8'h78, 10);
    run(8'hb7, 20);
    chk(nxt, 32'h1111_2222);
    run(8'h37, 20);
    run(8'h97, 20);
    run(8'h17, 20);
    run(8'hf7, 16);
    chk(top, 32'h1111_1111);
    run(8'h9a, 16);
    chk(nxt, 32'h1111_1111);
    run(8'h1a, 16);
    chk(nxt, FLT_PI);
    run(8'h77, 16);
    chk(top, 32'h4049_4049);
  endtask

  task automatic t_short(input logic [7:0] c, input logic [31:0] v, input int cy,
                         input logic [15:0] r, input logic [7:0] s);
    put32(v);
    run(c, cy);
    chk({16'h0, top[31:16]}, {16'h0, r});
    chk({24'h0, st}, {24'h0, s});
  endtask

  task automatic t_func();
    put32(32'hbf80_0000);
    run(8'h08, 20);
    chk(32'(st.err), 32'(ERR_DOMAIN));
    put32(32'h4120_0000);
    run(8'h88, 40);
    chk(top, ~32'h4120_0000);
    chk(nxt, 32'hbf80_0000);
    put32(32'h0000_0000);
    run(8'h89, 20);
    chk(32'(st.err), 32'(ERR_DOMAIN));
    put32(32'h3f80_0000);
    run(8'h09, 40);
    chk(top, ~32'h3f80_0000);
    put32(32'h4000_0000);
    put32(32'h3f00_0000);
    run(8'h8b, 40);
    chk(top, ~32'h3f00_0000);
    chk(nxt, ~32'h3f80_0000);
    put32(32'h4000_0000);
    put32(32'h4200_0000);
    bad_rng = 1'b1;
    run(8'h0b, 40);
    chk(32'(st.err), 32'(ERR_RANGE));
    bad_rng = 1'b0;
    put32(32'h3980_0000);
    run(8'h82, 30);
    chk(top, ~32'h3980_0000);
    put32(32'h4000_0000);
    run(8'h02, 3796);
    chk(top, ~32'h4000_0000);
  endtask

  task automatic t_idle();
    run(8'h80, 4);
    chk({24'h0, st}, 32'h0);
    chk(top, ~32'h4000_0000);
    chk({31'h0, svc_req}, 32'h1);
    svc_ack = 1'b1;
    @(negedge clk_i);
    svc_ack = 1'b0;
    @(negedge clk_i);
    chk({31'h0, svc_req}, 32'h0);
    run(8'h80, 4);
    run(8'h00, 4);
    chk({31'h0, svc_req}, 32'h0);
  endtask

  ////////////////////////////////////////////////////////////////////////////
  always @(posedge clk_i) begin
    cyc++;
    if (cyc == 20000) begin
      bad_count++;
      end_of_test();
    end
  end

  initial begin
    repeat (3) @(negedge clk_i);
    srst_i = 1'b0;
    t_stack();
    t_short(8'hec, 32'h0001_7fff, 16, 16'h8000, 8'h81);
    t_short(8'h6c, 32'h0001_ffff, 16, 16'h0000, 8'h42);
    t_short(8'h6f, 32'h0002_0007, 84, 16'h0003, 8'h00);
    t_short(8'hef, 32'h0000_0009, 14, 16'h0009, 8'h20);
    t_short(8'h6e, 32'h0003_0005, 84, 16'h000f, 8'h00);
    t_short(8'hee, 32'h8000_0003, 84, 16'h8000, 8'h81);
    t_func();
    t_idle();
    t_pop();
    end_of_test();
  end
endmodule // tb_top
